// ==== bench/cgo_handler_tb.sv ====
`timescale 1ns/1ps
module cgo_handler_tb;
  logic clk, arst_n, cv, cr, rv, rr, pv, pr, rej, stall;
  cgo_pkg::cgo_cmd_t cmd, rsp, pcmd, got;
  logic [15:0] gg, go, bg;
  int got_count, err_total, cmp_count, cyc;
  logic [7:0] codes [3] = '{8'h81, 8'h85, 8'h82};
  logic [15:0] vals [3] = '{16'h03FF, 16'h00FF, 16'h0060};
  cgo_handler cgo_handler_i (.CORE_CLK(clk), .ARST_N(arst_n),
    .CMD_VALID(cv), .CMD_READY(cr), .CMD(cmd), .RSP_VALID(rv),
    .RSP_READY(rr), .RSP(rsp), .PASS_VALID(pv), .PASS_READY(pr),
    .PASS_CMD(pcmd), .GREEN_GAIN(gg), .GREEN_OFFSET(go),
    .BLUE_GAIN(bg), .REJECT_PULSE(rej));
  cgo_host cgo_host_i (.clk(clk), .stall(stall), .rsp_valid(rv),
    .rsp(rsp), .rsp_ready(rr), .pass_ready(pr), .got(got),
    .got_count(got_count));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_cmd(string nm, logic [32:0] e, logic [32:0] s);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_all(logic [15:0] a, logic [15:0] b, logic [15:0] c);
    chk_val("green gain", a, gg);
    chk_val("green offset", b, go);
    chk_val("blue gain", c, bg);
  endtask
  // present a command and hold it until the take edge
  task automatic send(logic [7:0] c, logic f, logic [7:0] l, logic [15:0] v);
    @(negedge clk);
    cmd = {c, f, l, v[7:0], v[15:8]};
    cv = 1'b1;
    for (int n = 0; n < 50 && cr !== 1'b1; n++)
      @(negedge clk);
    @(posedge clk);
  endtask
  task automatic idle();
    @(negedge clk);
    cv = 1'b0;
  endtask
  task automatic bad(logic [7:0] c, logic [7:0] l, logic [15:0] v);
    send(c, 1'b0, l, v);
    idle();
    chk_val("reject", 16'h0001, {15'h0000, rej});
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    cv = 1'b0;
    cmd = '0;
    stall = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    chk_all(16'h0060, 16'h0000, 16'h0060);
    send(8'h81, 1'b0, 8'h02, 16'h03FF);
    send(8'h85, 1'b0, 8'h02, 16'h00FF);
    send(8'h82, 1'b0, 8'h02, 16'h0060);
    idle();
    chk_all(16'h03FF, 16'h00FF, 16'h0060);
    repeat (3) @(negedge clk);
    chk_val("replies", 16'h0000, got_count[15:0]);
    for (int i = 0; i < 3; i++)
    begin
      stall = (i == 1);
      send(codes[i], 1'b1, 8'h02, 16'h0000);
      idle();
      repeat (4) @(negedge clk);
      if (i == 1)
        chk_val("held reply", 16'h0003, {14'h0000, rv, ~cr});
      stall = 1'b0;
      for (int n = 0; n < 20 && got_count != i + 1; n++)
        @(negedge clk);
      chk_cmd("reply", {codes[i], 1'b0, 8'h02, vals[i][7:0],
        vals[i][15:8]}, got);
    end
    bad(8'h81, 8'h02, 16'h0400);
    bad(8'h85, 8'h02, 16'h0100);
    bad(8'h82, 8'h02, 16'h005F);
    bad(8'h81, 8'h01, 16'h0100);
    chk_all(16'h03FF, 16'h00FF, 16'h0060);
    stall = 1'b1;
    send(8'hA1, 1'b0, 8'h01, 16'h0003);
    idle();
    chk_val("pass valid", 16'h0001, {15'h0000, pv});
    chk_cmd("pass", {8'hA1, 1'b0, 8'h01, 8'h03, 8'h00}, pcmd);
    repeat (3) @(negedge clk);
    chk_val("pass held", 16'h0001, {15'h0000, pv});
    stall = 1'b0;
    repeat (3) @(negedge clk);
    chk_val("pass taken", 16'h0000, {15'h0000, pv});
    chk_all(16'h03FF, 16'h00FF, 16'h0060);
    test_done();
  end
endmodule

// ==== bench/cgo_host.sv ====
`timescale 1ns/1ps
module cgo_host
(
  // clock and stall request
  input wire logic clk,
  input wire logic stall,
  // reply and pass-on side
  input wire logic rsp_valid,
  input wire cgo_pkg::cgo_cmd_t rsp,
  output logic rsp_ready,
  output logic pass_ready,
  output cgo_pkg::cgo_cmd_t got,
  output int got_count
);
  initial
  begin
    rsp_ready = 1'b0;
    pass_ready = 1'b0;
    got = '0;
    got_count = 0;
  end
  // readiness changes just after an edge
  always @(posedge clk)
  begin
    rsp_ready <= !stall;
    pass_ready <= !stall;
    if (rsp_valid && rsp_ready)
    begin
      got <= rsp;
      got_count <= got_count + 1;
    end
  end
endmodule

// ==== hw/cgo_handler.sv ====
`timescale 1ns/1ps
module cgo_handler
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // decoded command in
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire cgo_pkg::cgo_cmd_t CMD,
  // response out
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output cgo_pkg::cgo_cmd_t RSP,
  // foreign command pass-on
  output logic PASS_VALID,
  input wire logic PASS_READY,
  output cgo_pkg::cgo_cmd_t PASS_CMD,
  // analog chain settings
  output logic [15:0] GREEN_GAIN,
  output logic [15:0] GREEN_OFFSET,
  output logic [15:0] BLUE_GAIN,
  // a write with bad length or value was dropped
  output logic REJECT_PULSE
);
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_REPLY, ST_PASS} cgo_state_t;
  cgo_state_t state_reg;
  logic [1:0] slot;
  logic [15:0] wr_value;
  logic in_range;
  logic accept;
  logic wr_en;
  logic [1:0] rd_slot_reg;
  logic [15:0] rd_data;
  logic [7:0] rsp_code_reg;

  function automatic logic [1:0] code_slot(input logic [7:0] code);
    unique case (code)
      cgo_pkg::CODE_GREEN_GAIN: code_slot = 2'(cgo_pkg::SLOT_GGAIN);
      cgo_pkg::CODE_GREEN_OFFSET: code_slot = 2'(cgo_pkg::SLOT_GOFF);
      cgo_pkg::CODE_BLUE_GAIN: code_slot = 2'(cgo_pkg::SLOT_BGAIN);
      default: code_slot = 2'd3;
    endcase
  endfunction

  assign slot = code_slot(CMD.code);
  assign wr_value = {CMD.data_hi, CMD.data_lo};
  assign CMD_READY = (state_reg == ST_IDLE);
  assign accept = CMD_VALID && CMD_READY;

  always_comb
  begin
    in_range = 1'b0;
    if (slot == 2'(cgo_pkg::SLOT_GOFF))
      in_range = wr_value <= cgo_pkg::OFFSET_MAX;
    else
      in_range = wr_value >= cgo_pkg::GAIN_MIN
                 && wr_value <= cgo_pkg::GAIN_MAX;
  end

  // out-of-range or misframed writes are dropped so the chain stays legal
  assign wr_en = accept && slot != 2'd3 && !CMD.read_flag
                 && CMD.length == cgo_pkg::SETTING_LEN && in_range;

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      REJECT_PULSE <= 1'b0;
    else
      REJECT_PULSE <= accept && slot != 2'd3 && !CMD.read_flag && !wr_en;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      state_reg <= ST_IDLE;
    else
      unique case (state_reg)
        ST_IDLE:
          if (accept)
          begin
            if (slot == 2'd3)
              state_reg <= ST_PASS;
            else if (CMD.read_flag)
              state_reg <= ST_FETCH;
          end
        ST_FETCH:
          state_reg <= ST_REPLY;
        ST_REPLY:
          if (RSP_READY)
            state_reg <= ST_IDLE;
        ST_PASS:
          if (PASS_READY)
            state_reg <= ST_IDLE;
      endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rd_slot_reg <= 2'd3;
      rsp_code_reg <= 8'h00;
    end
    else if (accept && CMD.read_flag && slot != 2'd3)
    begin
      rd_slot_reg <= slot;
      rsp_code_reg <= CMD.code;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      PASS_CMD <= '0;
    else if (accept && slot == 2'd3)
      PASS_CMD <= CMD;
  end

  cgo_store cgo_store_i
  (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .wr_en(wr_en),
    .wr_slot(slot),
    .wr_data(wr_value),
    .rd_slot(rd_slot_reg),
    .rd_data(rd_data),
    .green_gain(GREEN_GAIN),
    .green_offset(GREEN_OFFSET),
    .blue_gain(BLUE_GAIN)
  );

  assign RSP_VALID = (state_reg == ST_REPLY);
  assign PASS_VALID = (state_reg == ST_PASS);

  always_comb
  begin
    RSP.code = rsp_code_reg;
    RSP.read_flag = 1'b0;
    RSP.length = cgo_pkg::SETTING_LEN;
    RSP.data_lo = rd_data[7:0];
    RSP.data_hi = rd_data[15:8];
  end

  a_write_silent: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    wr_en |=> !RSP_VALID)
    else $error("reply after write");

  a_read_replies: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    accept && CMD.read_flag && slot != 2'd3 |-> ##2 RSP_VALID)
    else $error("read got no reply");

  a_reply_code: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    accept && CMD.read_flag && slot != 2'd3
    |-> ##2 RSP.code == $past(CMD.code, 2))
    else $error("reply code wrong");

  a_reply_frame: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    RSP_VALID |-> !RSP.read_flag && RSP.length == cgo_pkg::SETTING_LEN)
    else $error("reply frame wrong");

  a_ggain_range: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    GREEN_GAIN >= cgo_pkg::GAIN_MIN && GREEN_GAIN <= cgo_pkg::GAIN_MAX)
    else $error("green gain out of range");

  a_goff_range: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    GREEN_OFFSET <= cgo_pkg::OFFSET_MAX)
    else $error("green offset out of range");

  a_bgain_range: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    BLUE_GAIN >= cgo_pkg::GAIN_MIN && BLUE_GAIN <= cgo_pkg::GAIN_MAX)
    else $error("blue gain out of range");

  a_write_lands: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    wr_en && slot == 2'd2 |=> BLUE_GAIN == $past(wr_value))
    else $error("blue gain write lost");

  a_goff_write: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    wr_en && slot == 2'd1 |=> GREEN_OFFSET == $past(wr_value))
    else $error("green offset write lost");

  a_ggain_write: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    wr_en && slot == 2'd0 |=> GREEN_GAIN == $past(wr_value))
    else $error("green gain write lost");

  a_foreign_kept: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    accept && slot == 2'd3 |=> $stable(GREEN_GAIN) && $stable(BLUE_GAIN)
    && $stable(GREEN_OFFSET) && PASS_VALID)
    else $error("foreign code touched settings");

  // a pending reply must not move until the host has taken it
  a_reply_stands: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP))
    else $error("reply changed before taken");

  // reply carries the addressed setting, low byte in data_lo
  a_reply_data: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    RSP_VALID |-> {RSP.data_hi, RSP.data_lo}
    == (rd_slot_reg == 2'd0 ? GREEN_GAIN
    : rd_slot_reg == 2'd1 ? GREEN_OFFSET : BLUE_GAIN))
    else $error("reply data wrong");

  a_pass_stands: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    PASS_VALID && !PASS_READY |=> PASS_VALID && $stable(PASS_CMD))
    else $error("pass-on changed before taken");

  a_busy_refuses: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    RSP_VALID || PASS_VALID |-> !CMD_READY)
    else $error("command taken while busy");

  a_read_keeps: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    accept && CMD.read_flag && slot != 2'd3
    |=> $stable(GREEN_GAIN) && $stable(GREEN_OFFSET) && $stable(BLUE_GAIN))
    else $error("read changed a setting");

  a_range_dropped: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    accept && slot != 2'd3 && !CMD.read_flag && !in_range
    |=> REJECT_PULSE && $stable(GREEN_GAIN) && $stable(GREEN_OFFSET)
    && $stable(BLUE_GAIN))
    else $error("out-of-range write not dropped");

  a_length_dropped: assert property (
    @(posedge CORE_CLK) disable iff (!ARST_N)
    accept && slot != 2'd3 && !CMD.read_flag
    && CMD.length != cgo_pkg::SETTING_LEN
    |=> REJECT_PULSE && $stable(GREEN_GAIN) && $stable(GREEN_OFFSET)
    && $stable(BLUE_GAIN))
    else $error("misframed write not dropped");
endmodule

// ==== hw/cgo_pkg.sv ====
package cgo_pkg;
  localparam logic [7:0] CODE_GREEN_GAIN = 8'h81;
  localparam logic [7:0] CODE_GREEN_OFFSET = 8'h85;
  localparam logic [7:0] CODE_BLUE_GAIN = 8'h82;
  localparam logic [7:0] SETTING_LEN = 8'h02;
  localparam logic [15:0] GAIN_MIN = 16'h0060;
  localparam logic [15:0] GAIN_MAX = 16'h03FF;
  localparam logic [15:0] OFFSET_MIN = 16'h0000;
  localparam logic [15:0] OFFSET_MAX = 16'h00FF;
  localparam logic [15:0] GAIN_RESET = 16'h0060;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam int SLOT_GGAIN = 0;
  localparam int SLOT_GOFF = 1;
  localparam int SLOT_BGAIN = 2;

  typedef struct packed {
    logic [7:0] code;
    logic read_flag;
    logic [7:0] length;
    logic [7:0] data_lo;
    logic [7:0] data_hi;
  } cgo_cmd_t;
endpackage

// ==== hw/cgo_store.sv ====
`timescale 1ns/1ps
module cgo_store
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write side
  input wire logic wr_en,
  input wire logic [1:0] wr_slot,
  input wire logic [15:0] wr_data,
  // read side
  input wire logic [1:0] rd_slot,
  output logic [15:0] rd_data,
  // live values
  output logic [15:0] green_gain,
  output logic [15:0] green_offset,
  output logic [15:0] blue_gain
);
  logic [15:0] mem_reg [0:2];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_reg[cgo_pkg::SLOT_GGAIN] <= cgo_pkg::GAIN_RESET;
      mem_reg[cgo_pkg::SLOT_GOFF] <= cgo_pkg::OFFSET_RESET;
      mem_reg[cgo_pkg::SLOT_BGAIN] <= cgo_pkg::GAIN_RESET;
    end
    else if (wr_en && wr_slot != 2'd3)
    begin
      mem_reg[wr_slot] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data <= 16'h0000;
    else if (rd_slot != 2'd3)
      rd_data <= mem_reg[rd_slot];
    else
      rd_data <= 16'h0000;
  end

  assign green_gain = mem_reg[cgo_pkg::SLOT_GGAIN];
  assign green_offset = mem_reg[cgo_pkg::SLOT_GOFF];
  assign blue_gain = mem_reg[cgo_pkg::SLOT_BGAIN];
endmodule
